// File: can_sig_pkg.sv
// Shared constants and types for the CAN input signal extractors
package can_sig_pkg;

  // ----------------------------------------------------------------
  // Instance count and identifier layout
  // ----------------------------------------------------------------
  localparam int          NCH          = 3;        // Independent extractors
  localparam int          ID_W         = 29;       // Extended identifier width
  localparam int          PGN_W        = 18;       // Group number width
  localparam int          SA_LSB       = 0;        // Sender address position
  localparam int          PS_LSB       = 8;        // Specific field position
  localparam int          PF_LSB       = 16;       // Format field position
  localparam int          DP_LSB       = 24;       // Data page pair position
  localparam logic [7:0]  PDU2_MIN     = 8'hF0;    // Broadcast format boundary
  localparam logic [3:0]  DLC_MAX      = 4'h8;     // Single frame byte count

  // ----------------------------------------------------------------
  // Reset values of the configuration
  // ----------------------------------------------------------------
  localparam logic [17:0] PGN_DEFAULT  = 18'h0FF00; // 65280
  localparam logic [7:0]  ADDR_DEFAULT = 8'h00;
  localparam logic [7:0]  ADDR_MAX     = 8'hFD;     // 253
  localparam logic [3:0]  POS_DEFAULT  = 4'h1;      // Byte and bit position
  localparam logic [3:0]  POS_MAX      = 4'h8;
  localparam int          FRAC_BITS    = 16;        // Fixed point fraction bits
  localparam logic [31:0] RES_DEFAULT  = 32'h0001_0000; // 1.0
  localparam logic [31:0] OFS_DEFAULT  = 32'h0000_0000; // 0.0
  localparam logic [31:0] MAX_DEFAULT  = 32'h0001_0000; // 1.0
  localparam logic [31:0] MIN_DEFAULT  = 32'h0000_0000; // 0.0
  localparam logic [16:0] NORM_ONE     = 17'h10000;     // Normalized full scale
  localparam logic [13:0] ARST_DEFAULT = 14'h01F4;      // 500 ms
  localparam logic [13:0] ARST_MAX     = 14'h2710;      // 10000 ms

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          MS_US        = 1000;     // One millisecond in us
  localparam int          CLK_NS       = 20;       // Clock period
  localparam int          MS_CYCLES    = (MS_US * 1000) / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TYPE_UNDEF = 3'h0,
    TYPE_DISC1 = 3'h1,
    TYPE_DISC2 = 3'h2,
    TYPE_DISC4 = 3'h3,
    TYPE_CONT1 = 3'h4,
    TYPE_CONT2 = 3'h5,
    TYPE_CONT3 = 3'h6,
    TYPE_CONT4 = 3'h7
  } sig_type_t;

  // Gray ordered: not available -> valid -> error
  typedef enum logic [1:0] {
    ST_NA    = 2'h0,
    ST_VALID = 2'h1,
    ST_ERROR = 2'h3
  } sig_state_t;

endpackage

// File: field_if.sv
// Bundle between the frame path and one field extractor
`timescale 1ns/1ps
`default_nettype none
interface field_if;
  import can_sig_pkg::*;
  logic [63:0] data;      // Frame payload, byte 1 in bits 7:0
  logic [3:0]  dlc;       // Payload length
  sig_type_t   sig_type;  // Field format
  logic [3:0]  byte_pos;  // 1..8
  logic [3:0]  bit_pos;   // 1..8
  logic [31:0] raw;       // Extracted field, right aligned
  sig_state_t  cls;       // Value or indicator class
  logic        fits;      // Field lies inside the payload
  modport ctl  (output data, dlc, sig_type, byte_pos, bit_pos, input raw, cls, fits);
  modport extr (input data, dlc, sig_type, byte_pos, bit_pos, output raw, cls, fits);
endinterface
`default_nettype wire

// File: can_field_extract.sv
// Pulls one discrete or continuous field out of a payload and classifies it
`timescale 1ns/1ps
`default_nettype none
module can_field_extract
  import can_sig_pkg::*;
(
  // Field request and result
  field_if.extr f
);

  logic [2:0]  byte_idx;  // Zero based start byte
  logic [2:0]  bit_idx;   // Zero based start bit
  logic [63:0] shifted;   // Payload moved down to the start byte
  logic [7:0]  dbits;     // Start byte moved down to the start bit
  logic [4:0]  nbytes;    // Bytes a continuous field needs

  // ----------------------------------------------------------------
  // Extraction and indicator decode
  // ----------------------------------------------------------------
  always_comb begin
    byte_idx = 3'(f.byte_pos - 4'h1);
    bit_idx  = 3'(f.bit_pos - 4'h1);
    shifted  = f.data >> {byte_idx, 3'h0};
    dbits    = shifted[7:0] >> bit_idx;
    nbytes   = {2'h0, f.sig_type[1:0]} + 5'h1;
    f.raw    = 32'h0;
    f.cls    = ST_VALID;
    f.fits   = 1'b0;
    // Discrete fields must not cross into the next byte; such a setup is refused
    case (f.sig_type)
      TYPE_DISC1: begin
        f.raw  = {31'h0, dbits[0]};
        f.fits = 1'b1;
      end
      TYPE_DISC2: begin
        f.raw  = {30'h0, dbits[1:0]};
        f.fits = (bit_idx <= 3'h6);
        // 10 flags an error, 11 not available
        if (dbits[1:0] == 2'h2) begin
          f.cls = ST_ERROR;
        end else if (dbits[1:0] == 2'h3) begin
          f.cls = ST_NA;
        end
      end
      TYPE_DISC4: begin
        f.raw  = {28'h0, dbits[3:0]};
        f.fits = (bit_idx <= 3'h4);
        if (dbits[3:0] == 4'hE) begin
          f.cls = ST_ERROR;
        end else if (dbits[3:0] == 4'hF) begin
          f.cls = ST_NA;
        end
      end
      TYPE_CONT1, TYPE_CONT2, TYPE_CONT3, TYPE_CONT4: begin
        f.raw  = shifted[31:0] & (32'hFFFF_FFFF >> {3'(3'h3 - {1'b0, f.sig_type[1:0]}), 3'h0});
        f.fits = ({2'h0, byte_idx} + nbytes) <= {1'b0, f.dlc};
        // Indicators live in the most significant byte of the little-endian value
        case (f.raw[{f.sig_type[1:0], 3'h7} -: 8])
          8'hFF:   f.cls = ST_NA;
          8'hFE:   f.cls = ST_ERROR;
          8'hFB, 8'hFC, 8'hFD: f.cls = ST_ERROR;     // Reserved range treated as error
          default: f.cls = ST_VALID;
        endcase
      end
      default: begin
        f.cls  = ST_NA;
        f.fits = 1'b0;
      end
    endcase
    // Discrete fields also need their byte inside the payload
    if (!f.sig_type[2] && ({1'b0, byte_idx} >= f.dlc)) begin
      f.fits = 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: can_input_signals.sv
// Three receive-side CAN input signal extractors with internal loopback path
`timescale 1ns/1ps
`default_nettype none
module can_input_signals
  import can_sig_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES  // Clock cycles per millisecond
)(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  // Frames sampled from the bus
  input  wire logic                         rx_valid,
  input  wire logic [ID_W-1:0]              rx_id,
  input  wire logic                         rx_ext,
  input  wire logic [3:0]                   rx_dlc,
  input  wire logic [63:0]                  rx_data,
  // Frames sent by this controller, looped back
  input  wire logic                         tx_valid,
  input  wire logic [ID_W-1:0]              tx_id,
  input  wire logic [3:0]                   tx_dlc,
  input  wire logic [63:0]                  tx_data,
  // Configuration, written per extractor when cfg_we is high
  input  wire logic [NCH-1:0]               cfg_we,
  input  wire sig_type_t                    cfg_type,
  input  wire logic [PGN_W-1:0]             cfg_pgn,
  input  wire logic                         cfg_filt_en,
  input  wire logic [7:0]                   cfg_addr,
  input  wire logic [3:0]                   cfg_byte_pos,
  input  wire logic [3:0]                   cfg_bit_pos,
  input  wire logic [31:0]                  cfg_res,
  input  wire logic [31:0]                  cfg_ofs,
  input  wire logic [31:0]                  cfg_max,
  input  wire logic [31:0]                  cfg_min,
  input  wire logic [13:0]                  cfg_arst_ms,
  // Logical outputs of the extractors
  output logic      [NCH-1:0][16:0]         sig_value,
  output logic      [NCH-1:0][31:0]         sig_raw,
  output sig_state_t [NCH-1:0]              sig_state,
  output logic      [NCH-1:0]               sig_update,
  // Default connection to the analog output block
  output logic      [16:0]                  ao_value,
  output sig_state_t                        ao_state
);

  // ----------------------------------------------------------------
  // Loopback holding slot
  // ----------------------------------------------------------------
  logic                  lb_pend_r, lb_pend_nxt;    // Own frame waiting
  logic [ID_W-1:0]       lb_id_r, lb_id_nxt;
  logic [3:0]            lb_dlc_r, lb_dlc_nxt;
  logic [63:0]           lb_data_r, lb_data_nxt;
  // Selected frame, one cycle after a bus frame arrives or the slot drains
  logic                  fr_valid_r, fr_valid_nxt;
  logic [ID_W-1:0]       fr_id_r, fr_id_nxt;
  logic [3:0]            fr_dlc_r, fr_dlc_nxt;
  logic [63:0]           fr_data_r, fr_data_nxt;
  // Decoded identifier fields
  logic [PGN_W-1:0]      fr_pgn;
  logic [7:0]            fr_sa;
  // Millisecond prescaler
  logic [31:0]           ms_cnt_r, ms_cnt_nxt;
  logic                  ms_tick_r, ms_tick_nxt;
  // Analog output copy
  logic [16:0]           ao_value_nxt;
  sig_state_t            ao_state_nxt;

  // ----------------------------------------------------------------
  // Frame selection
  // ----------------------------------------------------------------
  // Bus frames win the cycle; an own frame waits in a one-deep slot so it is
  // never dropped by a collision. A second own frame arriving before the slot
  // drains replaces the first: the source sends far slower than this clock.
  always_comb begin
    lb_pend_nxt  = lb_pend_r;
    lb_id_nxt    = lb_id_r;
    lb_dlc_nxt   = lb_dlc_r;
    lb_data_nxt  = lb_data_r;
    fr_valid_nxt = 1'b0;
    fr_id_nxt    = fr_id_r;
    fr_dlc_nxt   = fr_dlc_r;
    fr_data_nxt  = fr_data_r;
    // Only extended single frames carry a group number
    if (rx_valid && rx_ext && (rx_dlc <= DLC_MAX)) begin
      fr_valid_nxt = 1'b1;
      fr_id_nxt    = rx_id;
      fr_dlc_nxt   = rx_dlc;
      fr_data_nxt  = rx_data;
    end else if (lb_pend_r) begin
      fr_valid_nxt = 1'b1;
      fr_id_nxt    = lb_id_r;
      fr_dlc_nxt   = lb_dlc_r;
      fr_data_nxt  = lb_data_r;
      lb_pend_nxt  = 1'b0;
    end
    // A new own frame sets the slot over any drain in the same cycle
    if (tx_valid && (tx_dlc <= DLC_MAX)) begin
      lb_pend_nxt = 1'b1;
      lb_id_nxt   = tx_id;
      lb_dlc_nxt  = tx_dlc;
      lb_data_nxt = tx_data;
    end
  end

  // Register the selection path
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lb_pend_r  <= 1'b0;
      lb_id_r    <= '0;
      lb_dlc_r   <= 4'h0;
      lb_data_r  <= 64'h0;
      fr_valid_r <= 1'b0;
      fr_id_r    <= '0;
      fr_dlc_r   <= 4'h0;
      fr_data_r  <= 64'h0;
    end else begin
      lb_pend_r  <= lb_pend_nxt;
      lb_id_r    <= lb_id_nxt;
      lb_dlc_r   <= lb_dlc_nxt;
      lb_data_r  <= lb_data_nxt;
      fr_valid_r <= fr_valid_nxt;
      fr_id_r    <= fr_id_nxt;
      fr_dlc_r   <= fr_dlc_nxt;
      fr_data_r  <= fr_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Identifier decode
  // ----------------------------------------------------------------
  // Peer-to-peer formats carry a destination in the specific field, so it is
  // not part of the group number there
  always_comb begin
    fr_sa = fr_id_r[SA_LSB +: 8];
    if (fr_id_r[PF_LSB +: 8] < PDU2_MIN) begin
      fr_pgn = {fr_id_r[DP_LSB +: 2], fr_id_r[PF_LSB +: 8], 8'h00};
    end else begin
      fr_pgn = fr_id_r[PS_LSB +: PGN_W];
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick shared by all timeouts
  // ----------------------------------------------------------------
  always_comb begin
    ms_tick_nxt = 1'b0;
    ms_cnt_nxt  = ms_cnt_r + 32'h1;
    if (ms_cnt_r >= 32'(MS_TICKS - 1)) begin
      ms_cnt_nxt  = 32'h0;
      ms_tick_nxt = 1'b1;
    end
  end

  // Register the prescaler
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_r  <= 32'h0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_cnt_r  <= ms_cnt_nxt;
      ms_tick_r <= ms_tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Extractor channels
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    sig_type_t          type_r, type_nxt;          // Field format
    logic [PGN_W-1:0]   pgn_r, pgn_nxt;            // Group number to match
    logic               filt_r, filt_nxt;          // Sender filter on
    logic [7:0]         addr_r, addr_nxt;          // Sender to accept
    logic [3:0]         bpos_r, bpos_nxt;          // Start byte
    logic [3:0]         ipos_r, ipos_nxt;          // Start bit
    logic [31:0]        res_r, res_nxt;            // Resolution, Q16.16
    logic [31:0]        ofs_r, ofs_nxt;            // Offset, Q16.16
    logic [31:0]        max_r, max_nxt;            // Upper limit, Q16.16
    logic [31:0]        min_r, min_nxt;            // Lower limit, Q16.16
    logic [13:0]        arst_r, arst_nxt;          // Autoreset in ms
    logic [13:0]        age_r, age_nxt;            // Ms since last match
    logic [16:0]        val_r, val_nxt;
    logic [31:0]        raw_r, raw_nxt;
    sig_state_t         st_r, st_nxt;
    logic               upd_r, upd_nxt;
    logic               hit;                       // Frame accepted
    logic signed [63:0] phys, clip, span, lo, hi;  // Q16.16 arithmetic
    logic [63:0]        quot;
    field_if            fld ();

    // Field pull from the selected frame
    can_field_extract u_extract (
      .f (fld.extr)
    );

    // Acceptance, scaling and timeout
    always_comb begin
      fld.data     = fr_data_r;
      fld.dlc      = fr_dlc_r;
      fld.sig_type = type_r;
      fld.byte_pos = bpos_r;
      fld.bit_pos  = ipos_r;
      // Configuration; out of range writes are refused and keep the old value
      type_nxt = type_r;
      pgn_nxt  = pgn_r;
      filt_nxt = filt_r;
      addr_nxt = addr_r;
      bpos_nxt = bpos_r;
      ipos_nxt = ipos_r;
      res_nxt  = res_r;
      ofs_nxt  = ofs_r;
      max_nxt  = max_r;
      min_nxt  = min_r;
      arst_nxt = arst_r;
      if (cfg_we[ch]) begin
        type_nxt = cfg_type;
        pgn_nxt  = cfg_pgn;
        filt_nxt = cfg_filt_en;
        res_nxt  = cfg_res;
        ofs_nxt  = cfg_ofs;
        if (cfg_addr <= ADDR_MAX) addr_nxt = cfg_addr;
        if (cfg_byte_pos != 4'h0 && cfg_byte_pos <= POS_MAX) bpos_nxt = cfg_byte_pos;
        if (cfg_bit_pos != 4'h0 && cfg_bit_pos <= POS_MAX) ipos_nxt = cfg_bit_pos;
        // Limits only load as a consistent pair
        if ($signed(cfg_max) > $signed(cfg_min)) begin
          max_nxt = cfg_max;
          min_nxt = cfg_min;
        end
        if (cfg_arst_ms <= ARST_MAX) arst_nxt = cfg_arst_ms;
      end
      hit = fr_valid_r && (fr_pgn == pgn_r)
            && (!filt_r || (fr_sa == addr_r))
            && (type_r != TYPE_UNDEF) && fld.fits;
      // Physical value and clip into the normalization window
      phys = 64'($signed({32'h0, fld.raw}) * $signed({{32{res_r[31]}}, res_r}))
             + $signed({{32{ofs_r[31]}}, ofs_r});
      lo   = $signed({{32{min_r[31]}}, min_r});
      hi   = $signed({{32{max_r[31]}}, max_r});
      clip = (phys < lo) ? lo : ((phys > hi) ? hi : phys);
      span = hi - lo;
      // Wide divider: trades area for a one-cycle result
      quot = 64'((clip - lo) <<< FRAC_BITS) / 64'(span);
      val_nxt = val_r;
      raw_nxt = raw_r;
      st_nxt  = st_r;
      upd_nxt = 1'b0;
      age_nxt = age_r;
      if (hit) begin
        raw_nxt = fld.raw;
        st_nxt  = fld.cls;
        upd_nxt = 1'b1;
        age_nxt = 14'h0;
        val_nxt = type_r[2] ? quot[16:0] : fld.raw[16:0];
      end else if (type_r == TYPE_UNDEF) begin
        st_nxt = ST_NA;
      end else if (ms_tick_r && (arst_r != 14'h0) && (st_r != ST_NA)) begin
        age_nxt = age_r + 14'h1;
        if ((age_r + 14'h1) >= arst_r) begin
          st_nxt = ST_NA;
        end
      end
    end

    // Register the channel state
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        type_r <= TYPE_UNDEF;
        pgn_r  <= PGN_DEFAULT;
        filt_r <= 1'b0;
        addr_r <= ADDR_DEFAULT;
        bpos_r <= POS_DEFAULT;
        ipos_r <= POS_DEFAULT;
        res_r  <= RES_DEFAULT;
        ofs_r  <= OFS_DEFAULT;
        max_r  <= MAX_DEFAULT;
        min_r  <= MIN_DEFAULT;
        arst_r <= ARST_DEFAULT;
        age_r  <= 14'h0;
        val_r  <= 17'h0;
        raw_r  <= 32'h0;
        st_r   <= ST_NA;
        upd_r  <= 1'b0;
      end else begin
        type_r <= type_nxt;
        pgn_r  <= pgn_nxt;
        filt_r <= filt_nxt;
        addr_r <= addr_nxt;
        bpos_r <= bpos_nxt;
        ipos_r <= ipos_nxt;
        res_r  <= res_nxt;
        ofs_r  <= ofs_nxt;
        max_r  <= max_nxt;
        min_r  <= min_nxt;
        arst_r <= arst_nxt;
        age_r  <= age_nxt;
        val_r  <= val_nxt;
        raw_r  <= raw_nxt;
        st_r   <= st_nxt;
        upd_r  <= upd_nxt;
      end
    end

    assign sig_value[ch]  = val_r;
    assign sig_raw[ch]    = raw_r;
    assign sig_state[ch]  = st_r;
    assign sig_update[ch] = upd_r;
  end

  // ----------------------------------------------------------------
  // Analog output feed
  // ----------------------------------------------------------------
  // Registered copy of the first extractor's next values so it tracks it exactly
  always_comb begin
    ao_value_nxt = g_ch[0].val_nxt;
    ao_state_nxt = g_ch[0].st_nxt;
  end

  // Register the analog output feed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ao_value <= 17'h0;
      ao_state <= ST_NA;
    end else begin
      ao_value <= ao_value_nxt;
      ao_state <= ao_state_nxt;
    end
  end

endmodule
`default_nettype wire

// File: can_input_signals_chk.sv
// Checker of the extractor outputs against their inputs
`timescale 1ns/1ps
`default_nettype none
module can_input_signals_chk
  import can_sig_pkg::*;
#(
  parameter int MS_TICKS = 10  // Cycles per millisecond tick
)(
  // Clock, reset and stimulus seen
  input wire logic                  clock,
  input wire logic                  arst_n,
  input wire logic                  rx_valid,
  input wire logic                  tx_valid,
  input wire logic [NCH-1:0]        cfg_we,
  input wire sig_type_t             cfg_type,
  input wire logic [13:0]           cfg_arst_ms,
  // Outputs watched
  input wire logic [NCH-1:0][16:0]  sig_value,
  input wire logic [NCH-1:0][31:0]  sig_raw,
  input wire sig_state_t [NCH-1:0]  sig_state,
  input wire logic [NCH-1:0]        sig_update,
  input wire logic [16:0]           ao_value,
  input wire sig_state_t            ao_state
);
  logic [13:0] arst_r, arst_nxt;  // Autoreset of extractor 0
  int          age_r, age_nxt;    // Cycles since its last update
  int          q_r, q_nxt;        // Cycles since its last write
  // Shadow of the first extractor, saturating so it never wraps
  always_comb begin
    arst_nxt = (cfg_we[0] && cfg_arst_ms <= ARST_MAX) ? cfg_arst_ms : arst_r;
    age_nxt = sig_update[0] ? 0 : (age_r < 99999 ? age_r + 1 : age_r);
    q_nxt = cfg_we[0] ? 0 : (q_r < 9 ? q_r + 1 : q_r);
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arst_r <= ARST_DEFAULT;
      age_r <= 0;
      q_r <= 0;
    end else begin
      arst_r <= arst_nxt;
      age_r <= age_nxt;
      q_r <= q_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_ao_value: assert property (ao_value == sig_value[0])
    else $error("analog value differs from extractor 0");
  a_ao_state: assert property (ao_state == sig_state[0])
    else $error("analog state differs from extractor 0");
  a_no_spurious: assert property ((!rx_valid && !tx_valid) ##1 !rx_valid |-> ##2 sig_update == '0)
    else $error("update without a frame");
  a_value_range: assert property (sig_value[0] <= NORM_ONE && sig_value[1] <= NORM_ONE)
    else $error("value beyond full scale");
  a_raw_hold: assert property ($changed(sig_raw[0]) |-> sig_update[0])
    else $error("raw field changed without update");
  a_undef_na: assert property (cfg_we[0] && cfg_type == TYPE_UNDEF |-> ##3 sig_state[0] == ST_NA)
    else $error("undefined format not forced to not available");
  a_timeout: assert property (arst_r != 0 && age_r > (arst_r + 2) * MS_TICKS |-> sig_state[0] == ST_NA)
    else $error("autoreset late");
  a_zero_hold: assert property (arst_r == 0 && q_r > 3 && !sig_update[0] |-> $stable(sig_state[0]))
    else $error("state changed with autoreset off");
endmodule
bind can_input_signals can_input_signals_chk #(.MS_TICKS(MS_TICKS)) chk (.clock, .arst_n,
  .rx_valid, .tx_valid, .cfg_we, .cfg_type, .cfg_arst_ms, .sig_value, .sig_raw, .sig_state,
  .sig_update, .ao_value, .ao_state);
`default_nettype wire

// File: can_ecu_model.sv
// Remote node on the network that sends single frames
`timescale 1ns/1ps
`default_nettype none
module can_ecu_model (
  // Clock
  input  wire logic        clock,
  // Frame toward the extractors
  output var  logic        rx_valid,
  output var  logic        rx_ext,
  output var  logic [28:0] rx_id,
  output var  logic [3:0]  rx_dlc,
  output var  logic [63:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_ext = 1'b0;
    rx_id = '0;
    rx_dlc = '0;
    rx_data = '0;
  end
  // One extended frame, strobed for one cycle
  task automatic send(logic [28:0] id, logic [3:0] dlc, logic [63:0] d);
    rx_id = id;
    rx_ext = 1'b1;
    rx_dlc = dlc;
    rx_data = d;
    rx_valid = 1'b1;
    @(posedge clock);
    #1 rx_valid = 1'b0;
    // Unqualified payload must not look like the old bytes
    rx_data = ~d;
  endtask
endmodule
`default_nettype wire

// File: tb_can_input_signals.sv
// Self-checking bench of the three extractors
`timescale 1ns/1ps
`default_nettype none
module tb_can_input_signals
  import can_sig_pkg::*;
;
  logic                 clock = 1'b0, arst_n = 1'b0, rx_valid, rx_ext, tx_valid = 1'b0;
  logic [ID_W-1:0]      rx_id, tx_id = 29'h18FF0080;
  logic [3:0]           rx_dlc, c_byte = 4'h2, c_bit = 4'h3;
  logic [63:0]          rx_data, tx_data = '0;
  logic [NCH-1:0]       cfg_we = '0, sig_update;
  sig_type_t            c_type = TYPE_DISC2;
  logic [PGN_W-1:0]     c_pgn = PGN_DEFAULT;
  logic                 c_filt = 1'b0;
  logic [7:0]           c_addr = 8'h00;
  logic [31:0]          c_res = RES_DEFAULT, c_max = MAX_DEFAULT;
  logic [31:0]          c_ofs = OFS_DEFAULT, c_min = MIN_DEFAULT;
  logic [13:0]          c_arst = ARST_DEFAULT;
  logic [NCH-1:0][16:0] sig_value;
  logic [NCH-1:0][31:0] sig_raw;
  sig_state_t [NCH-1:0] sig_state;
  logic [16:0]          ao_value;
  sig_state_t           ao_state;
  int                   fails = 0, n_checks = 0, t;
  localparam logic [28:0] ID0 = 29'h18FF0005;  // Default group, sender 5
  always #10 clock = ~clock;
  can_ecu_model ecu (.clock, .rx_valid, .rx_ext, .rx_id, .rx_dlc, .rx_data);
  // Short millisecond so timeouts take tens of cycles
  can_input_signals #(.MS_TICKS(10)) dut (.clock, .arst_n, .rx_valid, .rx_id, .rx_ext,
    .rx_dlc, .rx_data, .tx_valid, .tx_id, .tx_dlc(4'h8), .tx_data,
    .cfg_we, .cfg_type(c_type), .cfg_pgn(c_pgn), .cfg_filt_en(c_filt), .cfg_addr(c_addr),
    .cfg_byte_pos(c_byte), .cfg_bit_pos(c_bit), .cfg_res(c_res), .cfg_ofs(c_ofs),
    .cfg_max(c_max), .cfg_min(c_min), .cfg_arst_ms(c_arst), .sig_value, .sig_raw,
    .sig_state, .sig_update, .ao_value, .ao_state);
  // ---------------------------------------------------------------
  // Access and compare tasks, all entered just after an edge
  // ---------------------------------------------------------------
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wcfg(int ch);
    cfg_we[ch] = 1'b1;
    @(posedge clock);
    #1 cfg_we = '0;
  endtask
  task automatic lb(logic [63:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    @(posedge clock);
    #1 tx_valid = 1'b0;
  endtask
  // Bounded wait for the update pulse, then its state
  task automatic upd(int ch, sig_state_t s);
    int i;
    for (i = 0; i < 8 && sig_update[ch] !== 1'b1; i++) @(posedge clock) #1;
    cmp("update", 1, sig_update[ch]);
    if (i == 8) end_of_test();
    cmp("state", s, sig_state[ch]);
  endtask
  task automatic none(int ch);
    repeat (6) @(posedge clock) #1 cmp("no update", 0, sig_update[ch]);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    #1 arst_n = 1'b1;
    for (int k = 0; k < NCH; k++) cmp("state", ST_NA, sig_state[k]);
    wcfg(0);
    ecu.send(ID0, 4'h8, 64'h1400);
    upd(0, ST_VALID);
    cmp("value", 1, sig_value[0]);
    cmp("ao value", 1, ao_value);
    ecu.send(ID0, 4'h8, 64'h0800);
    upd(0, ST_ERROR);
    cmp("ao state", ST_ERROR, ao_state);
    ecu.send(ID0, 4'h1, 64'h0400);
    none(0);
    ecu.send(29'h18FE0005, 4'h8, 64'h0400);
    none(0);
    c_pgn = 18'h0EF00;
    wcfg(0);
    ecu.send(29'h18EF1233, 4'h8, 64'h0400);
    upd(0, ST_VALID);
    c_pgn = PGN_DEFAULT;
    c_filt = 1'b1;
    c_addr = 8'h21;
    wcfg(0);
    ecu.send(29'h18FF0022, 4'h8, 64'h0400);
    none(0);
    ecu.send(29'h18FF0021, 4'h8, 64'h0C00);
    upd(0, ST_NA);
    c_addr = 8'hFE;
    wcfg(0);
    ecu.send(29'h18FF00FE, 4'h8, 64'h0400);
    none(0);
    none(2);
    c_filt = 1'b0;
    c_type = TYPE_DISC4;
    wcfg(2);
    ecu.send(ID0, 4'h8, 64'h3800);
    upd(2, ST_ERROR);
    cmp("value", 17'h0000E, sig_value[2]);
    c_type = TYPE_DISC1;
    c_bit = 4'h8;
    wcfg(2);
    ecu.send(ID0, 4'h8, 64'h8000);
    upd(2, ST_VALID);
    cmp("value", 1, sig_value[2]);
    c_type = TYPE_CONT2;
    c_byte = 4'h3;
    c_max = 32'h0100_0000;
    wcfg(1);
    ecu.send(ID0, 4'h8, 64'h0080_0000);
    upd(1, ST_VALID);
    cmp("value", 17'h08000, sig_value[1]);
    cmp("raw", 32'h80, sig_raw[1]);
    c_res = 32'h0002_0000;
    wcfg(1);
    ecu.send(ID0, 4'h8, 64'h0080_0000);
    upd(1, ST_VALID);
    cmp("value", 17'h10000, sig_value[1]);
    ecu.send(ID0, 4'h8, 64'hFF00_0000);
    upd(1, ST_NA);
    c_type = TYPE_CONT3;
    c_res = RES_DEFAULT;
    c_ofs = 32'h0040_0000;
    c_min = 32'h0080_0000;
    wcfg(1);
    ecu.send(ID0, 4'h8, 64'h0080_0000);
    upd(1, ST_VALID);
    cmp("value", 17'h08000, sig_value[1]);
    c_type = TYPE_CONT4;
    wcfg(1);
    ecu.send(ID0, 4'h8, 64'h0000_FE00_0000_0000);
    upd(1, ST_ERROR);
    cmp("raw", 32'hFE00_0000, sig_raw[1]);
    c_type = TYPE_CONT1;
    c_byte = 4'h1;
    c_ofs = OFS_DEFAULT;
    c_min = MIN_DEFAULT;
    c_max = MAX_DEFAULT;
    c_arst = 14'h3;
    wcfg(0);
    @(posedge clock) #1 wcfg(2);
    lb(64'h01);
    upd(2, ST_VALID);
    cmp("value", 17'h10000, sig_value[2]);
    for (t = 0; t < 100 && sig_state[0] !== ST_NA; t++) @(posedge clock) #1;
    cmp("timeout", 1, t >= 20 && t <= 45);
    repeat (30) @(posedge clock) #1;
    cmp("state", ST_NA, sig_state[0]);
    cmp("held", 17'h10000, sig_value[0]);
    c_arst = 14'h0;
    wcfg(0);
    lb(64'h01);
    upd(0, ST_VALID);
    repeat (100) @(posedge clock);
    #1 cmp("state", ST_VALID, sig_state[0]);
    c_type = TYPE_UNDEF;
    wcfg(0);
    lb(64'h01);
    none(0);
    cmp("state", ST_NA, sig_state[0]);
    end_of_test();
  end
endmodule
`default_nettype wire
